// ===== shared/fir_link_if.sv
// Link between the sequencer and the sum-of-products filter
interface fir_link_if;
  logic                               in_valid;
  logic [fir_seq_pkg::DATA_W-1:0]     sample;
  logic [fir_seq_pkg::COEF_W-1:0]     coef;
  logic                               coef_first;
  logic                               out_valid;
  logic [fir_seq_pkg::ACC_W-1:0]      out_sum;
  modport filter (input in_valid, input sample, input coef,
                  input coef_first, output out_valid, output out_sum);
  modport seq    (output in_valid, output sample, output coef,
                  output coef_first, input out_valid, input out_sum);
endinterface : fir_link_if

// ===== shared/fir_seq_pkg.sv
// Shared constants for the extended-length FIR sequencer and filter
package fir_seq_pkg;
  localparam int TAPS          = 8;   // Filter length L
  localparam int CELLS         = 4;   // Sum-of-products cells N
  localparam int PERIOD        = TAPS + CELLS - 1; // Clocks per block
  localparam int PIPE_LAT      = 3;   // Input to first accumulator
  localparam int HISTORY       = TAPS - 1; // Samples re-presented
  localparam int DATA_W        = 8;
  localparam int COEF_W        = 8;
  localparam int ACC_W         = 26;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'hA; // PERIOD - 1
endpackage : fir_seq_pkg

// ===== src/fir_sequencer.sv
// Sequencer feeding samples and coefficients to the filter
module fir_sequencer (
  input  wire logic                             clk,
  input  wire logic                             resetn,
  fir_link_if.seq                               link,
  input  wire logic                             samp_valid,
  input  wire logic [fir_seq_pkg::DATA_W-1:0]   samp_data,
  output logic                                  samp_ready,
  input  wire logic [fir_seq_pkg::COEF_W*fir_seq_pkg::TAPS-1:0] coefs,
  output logic                                  res_valid,
  output logic [fir_seq_pkg::ACC_W-1:0]         res_sum
);
  localparam int L  = fir_seq_pkg::TAPS;
  localparam int N  = fir_seq_pkg::CELLS;
  localparam int H  = fir_seq_pkg::HISTORY;
  localparam int DW = fir_seq_pkg::DATA_W;
  localparam int CW = fir_seq_pkg::COEF_W;
  localparam int PW = fir_seq_pkg::CNT_W;

  // Block phase counter, modulo L+N-1
  logic [fir_seq_pkg::CNT_W-1:0] phase;
  logic                          primed; // History filled once
  logic [3:0]                    fill;
  logic [DW-1:0]                 hist [H];
  wire logic new_phase = (phase >= PW'(H)) || !primed;
  wire logic step = new_phase ? samp_valid : 1'b1;

  assign samp_ready = new_phase; // Stalls source during replay

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      phase <= '0;
    else if (step && primed)
      phase <= (phase == fir_seq_pkg::CNT_LAST) ? '0 : phase + 4'h1;
  end

  // History: shift in every accepted sample, keep the last H. Replay
  // reads land before any new sample of the block, so after N new
  // samples the window already starts N samples later.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < H; i++)
        hist[i] <= '0;
      primed <= 1'b0;
      fill   <= '0;
    end
    else if (samp_valid && samp_ready)
    begin
      for (int i = 0; i < H-1; i++)
        hist[i] <= hist[i+1];
      hist[H-1] <= samp_data;
      if (!primed)
      begin
        fill <= fill + 4'h1;
        if (fill == 4'(H - 1))
          primed <= 1'b1;
      end
    end
  end

  // Drive the link: sample, then coefficient C7..C0 then N-1 zeros
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      link.in_valid   <= 1'b0;
      link.sample     <= '0;
      link.coef       <= '0;
      link.coef_first <= 1'b0;
    end
    else
    begin
      link.in_valid <= primed && step;
      link.sample   <= (phase < PW'(H)) ?
                       hist[phase[2:0]] : samp_data;
      link.coef     <= (phase < PW'(L)) ?
                       coefs[(L-1-int'(phase))*CW +: CW] : '0;
      // Marker only with a real transfer, never while history fills
      link.coef_first <= primed && step && (phase == '0);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      res_valid <= 1'b0;
      res_sum   <= '0;
    end
    else
    begin
      res_valid <= link.out_valid;
      res_sum   <= link.out_sum;
    end
  end
endmodule : fir_sequencer

// ===== src/sum_of_products_filter.sv
// Four-cell sum-of-products filter with shifting coefficients
module sum_of_products_filter #(
  parameter int CELLS = fir_seq_pkg::CELLS,
  parameter int TAPS  = fir_seq_pkg::TAPS
) (
  input  wire logic   clk,
  input  wire logic   resetn,
  fir_link_if.filter  link,
  output logic        user_valid,
  output logic [fir_seq_pkg::ACC_W-1:0] user_sum
);
  localparam int DW = fir_seq_pkg::DATA_W;
  localparam int CW = fir_seq_pkg::COEF_W;
  localparam int AW = fir_seq_pkg::ACC_W;
  localparam int LAT = fir_seq_pkg::PIPE_LAT;

  // Refuse sizes the 8-bit tap counter and cell chain cannot serve
  if (CELLS < 1 || TAPS < CELLS || TAPS < 2 || TAPS > 255)
  begin : g_bad_size
    $error("Unsupported cell or tap count");
  end

  // Input pipeline; the tags ride with their data so nothing skews
  logic [DW-1:0] pipe_x   [LAT];
  logic [CW-1:0] pipe_c   [LAT];
  logic          pipe_f   [LAT];
  logic          pipe_v   [LAT];
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < LAT; i++)
      begin
        pipe_x[i] <= '0;
        pipe_c[i] <= '0;
        pipe_f[i] <= 1'b0;
        pipe_v[i] <= 1'b0;
      end
    end
    else
    begin
      pipe_x[0] <= link.sample;
      pipe_c[0] <= link.coef;
      pipe_f[0] <= link.coef_first & link.in_valid;
      pipe_v[0] <= link.in_valid;
      for (int i = 1; i < LAT; i++)
      begin
        pipe_x[i] <= pipe_x[i-1];
        pipe_c[i] <= pipe_c[i-1];
        pipe_f[i] <= pipe_f[i-1];
        pipe_v[i] <= pipe_v[i-1];
      end
    end
  end

  wire logic [DW-1:0] x_bcast = pipe_x[LAT-1];
  wire logic          adv     = pipe_v[LAT-1];

  // Coefficient chain; a first-marker travels with each coefficient
  logic [CW-1:0] cell_c [CELLS];
  logic          cell_f [CELLS];
  logic [7:0]    cell_n [CELLS]; // Taps accumulated so far
  logic [AW-1:0] acc    [CELLS];
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < CELLS; i++)
      begin
        cell_c[i] <= '0;
        cell_f[i] <= 1'b0;
      end
    end
    else if (adv)
    begin
      cell_c[0] <= pipe_c[LAT-1];
      cell_f[0] <= pipe_f[LAT-1];
      for (int i = 1; i < CELLS; i++)
      begin
        cell_c[i] <= cell_c[i-1];
        cell_f[i] <= cell_f[i-1];
      end
    end
  end

  // Products use the coefficient arriving at each cell this clock
  function automatic logic [AW-1:0] prod(input logic [CW-1:0] c,
                                         input logic [DW-1:0] x);
    logic signed [CW+DW-1:0] p;
    p = $signed(c) * $signed(x);
    return AW'(p);
  endfunction : prod

  logic [CW-1:0] in_c [CELLS];
  logic          in_f [CELLS];
  always_comb
  begin
    in_c[0] = pipe_c[LAT-1];
    in_f[0] = pipe_f[LAT-1];
    for (int i = 1; i < CELLS; i++)
    begin
      in_c[i] = cell_c[i-1];
      in_f[i] = cell_f[i-1];
    end
  end

  // Accumulators; a full sum is read and cleared in the same clock
  logic          done_v;
  logic [AW-1:0] done_sum;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < CELLS; i++)
      begin
        acc[i]    <= '0;
        cell_n[i] <= '0;
      end
      done_v   <= 1'b0;
      done_sum <= '0;
    end
    else
    begin
      done_v <= 1'b0;
      if (adv)
      begin
        for (int i = 0; i < CELLS; i++)
        begin
          if (in_f[i])
          begin
            acc[i]    <= prod(in_c[i], x_bcast);
            cell_n[i] <= 8'h01;
          end
          else if (cell_n[i] == 8'(TAPS - 1))
          begin
            // Tap count reached: hand out, restart at zero
            done_sum  <= acc[i] + prod(in_c[i], x_bcast);
            done_v    <= 1'b1;
            acc[i]    <= '0;
            cell_n[i] <= '0;
          end
          else if (cell_n[i] != 8'h00)
          begin
            acc[i]    <= acc[i] + prod(in_c[i], x_bcast);
            cell_n[i] <= cell_n[i] + 8'h01;
          end
        end
      end
    end
  end

  // Registered output; invalid clocks show zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      user_valid <= 1'b0;
      user_sum   <= '0;
    end
    else
    begin
      user_valid <= done_v;
      user_sum   <= done_v ? done_sum : '0;
    end
  end

  assign link.out_valid = user_valid;
  assign link.out_sum   = user_sum;
endmodule : sum_of_products_filter

// ===== tb/extended_length_fir_sequencer_assertions.sv
// Link checks between the sequencer and the filter
module extended_length_fir_sequencer_assertions (
  input wire logic                           clk,
  input wire logic                           resetn,
  input wire logic                           in_valid,
  input wire logic [fir_seq_pkg::DATA_W-1:0] sample,
  input wire logic [fir_seq_pkg::COEF_W-1:0] coef,
  input wire logic                           coef_first,
  input wire logic                           out_valid,
  input wire logic [fir_seq_pkg::ACC_W-1:0]  out_sum
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Source is never starved, so blocks must follow back to back
  chk_four_outputs:
    assert property ($rose(out_valid) |-> out_valid[*4] ##1 !out_valid)
    else $error("output burst not four clocks");
  chk_block_period:
    assert property ($rose(out_valid) |-> ##11 $rose(out_valid))
    else $error("output blocks not eleven clocks apart");
  chk_idle_zero:
    assert property (!out_valid |-> out_sum == '0)
    else $error("sum not zero while invalid");
  chk_zero_tail:
    assert property (coef_first |-> ##8 (coef == '0)[*3])
    else $error("coefficient tail not three zeros");
  chk_restart:
    assert property (coef_first |-> ##11 coef_first)
    else $error("coefficient restart not at eleven");
  chk_eight_taps:
    assert property (coef_first |-> ##1 (!coef_first)[*8])
    else $error("coefficient sequence cut short");
  chk_steady_input:
    assert property (coef_first |-> in_valid[*8])
    else $error("sample missing inside a block");
  chk_replay:
    assert property (coef_first && $past(coef_first, 11)
      |-> sample == $past(sample, 7))
    else $error("block did not restart from fifth sample");
  // Window allows for either output register stage
  chk_latency:
    assert property (coef_first |-> ##[10:12] out_valid)
    else $error("first sum late or missing");
  cover property ($rose(out_valid) ##11 $rose(out_valid));
  cover property (coef_first ##11 coef_first);
  cover property (out_valid[*4]);
endmodule : extended_length_fir_sequencer_assertions

// ===== tb/tb_extended_length_fir_sequencer.sv
// Self-checking bench for the sequencer and filter pair
module tb_extended_length_fir_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [63:0] c; int m; int s; } row_t;
  logic                          clk = 1'b0;
  logic                          resetn = 1'b0;
  logic                          samp_valid = 1'b1;
  logic [fir_seq_pkg::DATA_W-1:0] samp_data = 8'h00;
  logic [63:0]                   coefs = 64'h0;
  logic                          samp_ready;
  logic                          res_valid;
  logic                          user_valid;
  logic [fir_seq_pkg::ACC_W-1:0] res_sum;
  logic [fir_seq_pkg::ACC_W-1:0] user_sum;
  logic [fir_seq_pkg::DATA_W-1:0] xs[$];
  logic [fir_seq_pkg::ACC_W-1:0] outs[$];
  logic [fir_seq_pkg::ACC_W-1:0] uq[$];
  int                            ts[$];
  int                            n_errors = 0;
  int                            comparisons = 0;
  int                            cyc = 0;
  int                            m = 0;
  int                            s = 0;
  // Boundary rows: ramp, sign extremes, impulse, full negative scale
  row_t rows[4] = '{'{64'h0102030405060708, 53, 7},
    '{64'h80FF7F0180FF7F01, 97, 3}, '{64'h0000000000000001, 29, 200},
    '{64'h8080808080808080, 0, 128}};
  fir_link_if link ();
  fir_sequencer u_fir_sequencer (.clk(clk), .resetn(resetn), .link(link),
    .samp_valid(samp_valid), .samp_data(samp_data),
    .samp_ready(samp_ready), .coefs(coefs), .res_valid(res_valid),
    .res_sum(res_sum));
  sum_of_products_filter u_sum_of_products_filter (.clk(clk),
    .resetn(resetn), .link(link), .user_valid(user_valid),
    .user_sum(user_sum));
  extended_length_fir_sequencer_assertions
    u_extended_length_fir_sequencer_assertions (.clk(clk),
    .resetn(resetn), .in_valid(link.in_valid), .sample(link.sample),
    .coef(link.coef), .coef_first(link.coef_first),
    .out_valid(link.out_valid), .out_sum(link.out_sum));
  always #2.5 clk = ~clk;
  // Log accepted samples and finished sums before the edge updates land
  always @(posedge clk)
  begin
    cyc++;
    if (resetn && samp_valid && samp_ready) xs.push_back(samp_data);
    if (user_valid) uq.push_back(user_sum);
    if (res_valid)
    begin
      outs.push_back(res_sum);
      ts.push_back(cyc);
    end
  end
  // Sample value is a pure function of its index, so replays are checkable;
  // the source stalls now and then while the history fills
  always @(negedge clk)
  begin
    samp_data  <= 8'(xs.size() * m + s);
    samp_valid <= (xs.size() >= 7) || (cyc % 3 != 0);
  end
  function automatic logic [fir_seq_pkg::ACC_W-1:0] y(input int n);
    int acc;
    acc = 0;
    for (int k = 0; k < 8; k++)
      acc += $signed(coefs[8*k +: 8]) * $signed(xs[n-k]);
    return acc[fir_seq_pkg::ACC_W-1:0];
  endfunction : y
  task automatic chk_sum(input logic [fir_seq_pkg::ACC_W-1:0] g, e);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_sum
  task automatic chk_gap(input int g, e);
    comparisons++;
    if (g != e)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_gap
  task automatic close_out;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // Each row resets mid-stream, then checks two blocks of four sums
  initial
  begin
    foreach (rows[r])
    begin
      @(negedge clk);
      resetn = 1'b0;
      coefs = rows[r].c;
      m = rows[r].m;
      s = rows[r].s;
      xs.delete();
      outs.delete();
      uq.delete();
      ts.delete();
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      for (int i = 0; i < 200 && outs.size() < 8; i++) @(negedge clk);
      if (outs.size() < 8 || uq.size() < 8)
      begin
        // Timed out: count it and leave the row loop for the final reset check and report
        n_errors++;
        $display("ERROR t=%0t got %h exp %h", $time, outs.size(), 8);
        break;
      end
      else
      begin
        for (int i = 0; i < 8; i++)
        begin
          chk_sum(outs[i], y(7 + i));
          chk_sum(uq[i], y(7 + i));
        end
        chk_gap(ts[3] - ts[0], 3);
        chk_gap(ts[4] - ts[0], 11);
      end
    end
    // Reset mid-block must silence both output paths
    resetn = 1'b0;
    @(negedge clk);
    chk_sum(res_sum | user_sum, 26'h0000000);
    chk_sum({24'h000000, res_valid, user_valid}, 26'h0000000);
    close_out();
  end
endmodule : tb_extended_length_fir_sequencer
